//--- verif/pllcfg_properties.sv
`timescale 1ns/10ps
module pllcfg_properties #(
  parameter int CAL_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pll_powered_down,
  input wire logic dist_from_vco,
  input wire logic vco_div_bypassed,
  input wire logic [2:0] vco_div_ratio,
  input wire logic pump_up,
  input wire logic pump_dn,
  input wire logic pump_hiz,
  input wire logic vco_cal_busy
);
  // config copy happens one edge after the update write, outputs one edge later
  wire upd_acc = psel && penable && pready && pwrite && paddr[11:2] == 10'h232
    && pwdata[7:0] == 8'h01;
  wire mapped = paddr[11:2] inside {10'h010, 10'h017, 10'h018, 10'h1e0, 10'h1e1, 10'h232,
    10'h233, 10'h234};
  logic [15:0] cal_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cal_cnt <= '0;
    else cal_cnt <= vco_cal_busy ? cal_cnt + 16'h1 : '0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans;
    psel && !penable |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_unmapped;
    psel && !penable && !mapped |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped index");
  // flag and pump commands leave the same edge, so no settling time is allowed
  property p_pd_hiz;
    pll_powered_down |-> pump_hiz && !pump_up && !pump_dn;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("pump active while powered down");
  property p_ratio;
    vco_div_ratio inside {[3'h2:3'h6]};
  endproperty
  a_ratio: assert property (p_ratio) else $error("divider ratio out of range");
  property p_held;
    $changed({vco_div_ratio, dist_from_vco, vco_div_bypassed, pll_powered_down})
      |-> $past(upd_acc, 3);
  endproperty
  a_held: assert property (p_held) else $error("config changed without update");
  property p_cal_start;
    $rose(vco_cal_busy) |-> $past(upd_acc, 2) ##1 dist_from_vco;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration without update");
  property p_cal_len;
    $fell(vco_cal_busy) |-> cal_cnt == CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
endmodule : pllcfg_properties

bind pllcfg_top pllcfg_properties #(.CAL_CYCLES(CAL_CYCLES)) i_pllcfg_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .pll_powered_down(pll_powered_down), .dist_from_vco(dist_from_vco),
  .vco_div_bypassed(vco_div_bypassed), .vco_div_ratio(vco_div_ratio), .pump_up(pump_up),
  .pump_dn(pump_dn), .pump_hiz(pump_hiz), .vco_cal_busy(vco_cal_busy));

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ref_div_in = 0, fb_div_in = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, rerr, pll_powered_down, dist_from_vco, vco_div_bypassed;
  logic pump_up, pump_dn, pump_hiz, vco_cal_busy;
  logic [2:0] vco_div_ratio, pump_current_setting;
  logic [1:0] antibacklash_sel;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  pllcfg_top #(.CAL_CYCLES(8)) i_pllcfg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_div_in(ref_div_in), .fb_div_in(fb_div_in), .pll_powered_down(pll_powered_down),
    .dist_from_vco(dist_from_vco), .vco_div_bypassed(vco_div_bypassed),
    .vco_div_ratio(vco_div_ratio), .antibacklash_sel(antibacklash_sel),
    .pump_current_setting(pump_current_setting), .pump_up(pump_up), .pump_dn(pump_dn),
    .pump_hiz(pump_hiz), .vco_cal_busy(vco_cal_busy));
  task wrap_up;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // idle cycle after each transfer keeps psel from being driven twice in one step
  task xfer(input logic w, input logic [9:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task rd_chk(input logic [9:0] i, input logic [31:0] e);
    xfer(1'b0, i, 8'h00);
    chk(rdata, e);
    chk(rerr, 1'b0);
  endtask : rd_chk
  task upd;
    xfer(1'b1, 10'h232, 8'h01);
    tick(2);
  endtask : upd
  task pulse(input logic [2:0] e);
    ref_div_in <= 1'b1;
    tick(8);
    chk({pump_up, pump_dn, pump_hiz}, e);
    fb_div_in <= 1'b1;
    tick(10);
    chk({pump_up, pump_dn, pump_hiz}, 3'b000);
    ref_div_in <= 1'b0;
    fb_div_in <= 1'b0;
    tick(4);
  endtask : pulse
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    tick(3);
    presetn <= 1'b1;
    chk({pll_powered_down, dist_from_vco, vco_div_bypassed, vco_div_ratio, pump_hiz,
      vco_cal_busy, antibacklash_sel, pump_current_setting}, 13'b1001001000000);
    rd_chk(10'h010, 32'h31);
    rd_chk(10'h1e0, 32'h02);
    rd_chk(10'h1e1, 32'h00);
    xfer(1'b0, 10'h100, 8'h00);
    chk(rerr, 1'b1);
    xfer(1'b1, 10'h234, 8'hff);
    chk(rerr, 1'b1);
    for (int c = 0; c < 5; c++) begin
      xfer(1'b1, 10'h1e0, 8'(c));
      chk(vco_div_ratio, (c == 0) ? 4 : c + 1);
      upd;
      chk(vco_div_ratio, c + 2);
    end
    xfer(1'b1, 10'h1e0, 8'h05);
    upd;
    chk(vco_div_ratio, 6);
    xfer(1'b1, 10'h1e0, 8'h00);
    xfer(1'b1, 10'h232, 8'h03);
    tick(2);
    chk(vco_div_ratio, 6);
    xfer(1'b1, 10'h1e1, 8'h01);
    upd;
    chk({dist_from_vco, vco_div_bypassed}, 2'b01);
    xfer(1'b1, 10'h1e1, 8'h02);
    upd;
    chk({dist_from_vco, vco_div_bypassed}, 2'b10);
    xfer(1'b1, 10'h018, 8'h01);
    upd;
    chk(vco_cal_busy, 1'b1);
    tick(10);
    chk(vco_cal_busy, 1'b0);
    upd;
    chk(vco_cal_busy, 1'b0);
    xfer(1'b1, 10'h018, 8'h00);
    upd;
    xfer(1'b1, 10'h018, 8'h01);
    upd;
    chk(vco_cal_busy, 1'b1);
    tick(10);
    xfer(1'b1, 10'h017, 8'h03);
    xfer(1'b1, 10'h233, 8'h07);
    rd_chk(10'h017, 32'h03);
    rd_chk(10'h233, 32'h07);
    upd;
    chk({antibacklash_sel, pump_current_setting}, 5'b11111);
    xfer(1'b1, 10'h1e1, 8'h01);
    for (int m = 0; m < 5; m++) begin
      xfer(1'b1, 10'h010, {1'b0, 3'(m), 4'h0});
      upd;
      chk({pll_powered_down, pump_up, pump_dn, pump_hiz},
        (m == 1) ? 4'b0100 : (m == 2) ? 4'b0010 : (m == 3) ? 4'b0000 : 4'b0001);
    end
    xfer(1'b1, 10'h010, 8'h30);
    upd;
    pulse(3'b100);
    xfer(1'b1, 10'h010, 8'hb0);
    upd;
    pulse(3'b010);
    xfer(1'b1, 10'h1e1, 8'h02);
    upd;
    pulse(3'b100);
    xfer(1'b1, 10'h010, 8'h31);
    upd;
    tick(2);
    chk({pll_powered_down, pump_up, pump_dn, pump_hiz}, 4'b1001);
    rd_chk(10'h234, 32'h82);
    wrap_up;
  end
endmodule : testbench

//--- verilog/pllcfg_pkg.sv
package pllcfg_pkg;
  typedef enum logic [2:0] {
    PLLCFG_CP_HIZ = 3'h0,
    PLLCFG_CP_UP = 3'h1,
    PLLCFG_CP_DN = 3'h2,
    PLLCFG_CP_NORMAL = 3'h3
  } pllcfg_cp_mode_t;

  typedef enum logic [2:0] {
    PLLCFG_CAL_IDLE = 3'b001,
    PLLCFG_CAL_RUN = 3'b010,
    PLLCFG_CAL_DONE = 3'b100
  } pllcfg_cal_state_t;

  typedef struct packed {
    logic pol_neg;
    logic [2:0] cp_mode;
    logic [1:0] pwr;
    logic [1:0] abl;
    logic cal;
    logic [2:0] pump_current_setting;
    logic [2:0] ratio_code;
    logic div_bypass;
    logic src_vco;
  } pllcfg_cfg_t;

  typedef struct packed {
    logic up;
    logic dn;
    logic hiz;
  } pllcfg_pump_t;
endpackage : pllcfg_pkg

//--- verilog/pllcfg_regs.svh
`ifndef PLLCFG_REGS_SVH
`define PLLCFG_REGS_SVH
// register indices; byte address is four times the index
`define PLLCFG_IDX_PWR_POL_PUMP 10'h010
`define PLLCFG_IDX_ANTIBACKLASH 10'h017
`define PLLCFG_IDX_VCO_CAL 10'h018
`define PLLCFG_IDX_VCO_DIV 10'h1e0
`define PLLCFG_IDX_DIST_SRC 10'h1e1
`define PLLCFG_IDX_UPDATE 10'h232
`define PLLCFG_IDX_PUMP_CUR 10'h233
`define PLLCFG_IDX_STATUS 10'h234
// field positions
`define PLLCFG_PWR_LSB 0
`define PLLCFG_CPMODE_LSB 4
`define PLLCFG_POL_BIT 7
`define PLLCFG_DIV_BYPASS_BIT 0
`define PLLCFG_SRC_VCO_BIT 1
`define PLLCFG_CAL_BIT 0
`define PLLCFG_UPD_BIT 0
// reset values
`define PLLCFG_RST_PWR 2'h1
`define PLLCFG_RST_RATIO 3'h2
`define PLLCFG_RST_CPMODE 3'h3
`define PLLCFG_RST_CUR 3'h0
// encodings and counts
`define PLLCFG_PWR_ON 2'h0
`define PLLCFG_UPD_VALUE 8'h01
`define PLLCFG_RATIO_MAX_CODE 3'h4
`define PLLCFG_RATIO_BASE 3'h2
`define PLLCFG_CAL_CYCLES 1024
`endif

//--- verilog/pllcfg_top.sv
`timescale 1ns/10ps
`include "pllcfg_regs.svh"
// Overview of operation
// - power field 00b runs the PLL, 01b powers it down synchronously, once the update is applied.
// - bypass bit clear uses VCO divider output; set routes source past it.
// - source bit 1 selects internal VCO, 0 selects external clock input.
// - three-bit ratio field sets VCO divider to two through six.
// - staged settings take effect only after host writes 0x01 to update.
// - setting the calibration bit plus update starts VCO calibration when the source bit selects the VCO.
// - polarity bit zero is positive, one is negative.
// - polarity only applies with an external VCO or VCXO.
// - two-bit field sets antibacklash pulse width.
// - pump mode selects high impedance, normal, constant up or constant down.
// - pump current is programmable in eight equal steps.
// - detector compares reference and feedback dividers, drives pump up or down.
// - reset defaults: PLL off, ratio four, divider used, external clock.
module pllcfg_top
  import pllcfg_pkg::*;
#(
  parameter int CAL_CYCLES = `PLLCFG_CAL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_div_in,
  input wire logic fb_div_in,
  output logic pll_powered_down,
  output logic dist_from_vco,
  output logic vco_div_bypassed,
  output logic [2:0] vco_div_ratio,
  output logic [1:0] antibacklash_sel,
  output logic [2:0] pump_current_setting,
  output logic pump_up,
  output logic pump_dn,
  output logic pump_hiz,
  output logic vco_cal_busy
);

  localparam pllcfg_cfg_t CFG_RESET = '{
    pol_neg: 1'b0,
    cp_mode: `PLLCFG_RST_CPMODE,
    pwr: `PLLCFG_RST_PWR,
    abl: 2'h0,
    cal: 1'b0,
    pump_current_setting: `PLLCFG_RST_CUR,
    ratio_code: `PLLCFG_RST_RATIO,
    div_bypass: 1'b0,
    src_vco: 1'b0
  };

  pllcfg_cfg_t staged_reg, staged_next;
  pllcfg_cfg_t active_reg;
  logic upd_reg, upd_next;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  pllcfg_cal_state_t cal_state_reg, cal_state_next;
  logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_reg;
  logic up_reg, dn_reg;
  logic [2:0] abl_cnt_reg;
  pllcfg_pump_t pump_reg, pump_next;

  // apb decode
  wire [9:0] idx = paddr[11:2];
  wire setup = psel & ~penable;
  wire wr_take = psel & penable & pready_reg & pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire hit_pwr = idx == `PLLCFG_IDX_PWR_POL_PUMP;
  wire hit_abl = idx == `PLLCFG_IDX_ANTIBACKLASH;
  wire hit_cal = idx == `PLLCFG_IDX_VCO_CAL;
  wire hit_div = idx == `PLLCFG_IDX_VCO_DIV;
  wire hit_src = idx == `PLLCFG_IDX_DIST_SRC;
  wire hit_upd = idx == `PLLCFG_IDX_UPDATE;
  wire hit_cur = idx == `PLLCFG_IDX_PUMP_CUR;
  wire hit_sts = idx == `PLLCFG_IDX_STATUS;
  wire mapped = hit_pwr | hit_abl | hit_cal | hit_div | hit_src | hit_upd | hit_cur | hit_sts;
  // status is read-only; a write to it is refused
  wire bad = ~mapped | (pwrite & hit_sts);
  wire wr_pwr = wr_take & hit_pwr;
  wire wr_abl = wr_take & hit_abl;
  wire wr_cal = wr_take & hit_cal;
  wire wr_div = wr_take & hit_div & (wb[2:0] <= `PLLCFG_RATIO_MAX_CODE);
  wire wr_src = wr_take & hit_src;
  wire wr_cur = wr_take & hit_cur;

  wire [7:0] rd_pwr = {staged_reg.pol_neg, staged_reg.cp_mode, 2'h0, staged_reg.pwr};
  wire [7:0] rd_sts = {active_reg.src_vco, active_reg.div_bypass, active_reg.ratio_code,
                       ~cal_state_reg[0], active_reg.pwr != `PLLCFG_PWR_ON, upd_reg};
  wire [7:0] rd_byte =
    hit_pwr ? rd_pwr :
    hit_abl ? {6'h0, staged_reg.abl} :
    hit_cal ? {7'h0, staged_reg.cal} :
    hit_div ? {5'h0, staged_reg.ratio_code} :
    hit_src ? {6'h0, staged_reg.src_vco, staged_reg.div_bypass} :
    hit_upd ? {7'h0, upd_reg} :
    hit_cur ? {5'h0, staged_reg.pump_current_setting} :
    hit_sts ? rd_sts : 8'h00;

  // staged writes; codes above four keep the previous ratio
  always_comb begin
    staged_next = staged_reg;
    if (wr_pwr) begin
      staged_next.pwr = wb[`PLLCFG_PWR_LSB +: 2];
      staged_next.cp_mode = wb[`PLLCFG_CPMODE_LSB +: 3];
      staged_next.pol_neg = wb[`PLLCFG_POL_BIT];
    end
    if (wr_abl) begin
      staged_next.abl = wb[1:0];
    end
    if (wr_cal) begin
      staged_next.cal = wb[`PLLCFG_CAL_BIT];
    end
    if (wr_div) begin
      staged_next.ratio_code = wb[2:0];
    end
    if (wr_src) begin
      staged_next.div_bypass = wb[`PLLCFG_DIV_BYPASS_BIT];
      staged_next.src_vco = wb[`PLLCFG_SRC_VCO_BIT];
    end
    if (wr_cur) begin
      staged_next.pump_current_setting = wb[2:0];
    end
  end

  // only the exact value arms the update; the copy happens next cycle
  wire upd_write = wr_take & hit_upd & (wb == `PLLCFG_UPD_VALUE);
  assign upd_next = upd_write | 1'b0;
  wire apply = upd_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      staged_reg <= CFG_RESET;
    end else begin
      staged_reg <= staged_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_reg <= 1'b0;
    end else begin
      upd_reg <= upd_next;
    end
  end

  // every field moves on one edge, so no half-applied set is ever live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= CFG_RESET;
    end else if (apply) begin
      active_reg <= staged_reg;
    end
  end

  // zero-wait slave: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & bad;
      prdata_reg <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // calibration starts only on a 0 to 1 edge of the active bit, hence the clear-then-set
  wire cal_edge = apply & staged_reg.cal & ~active_reg.cal;
  wire cal_go = cal_edge & staged_reg.src_vco;
  wire cal_last = cal_cnt_reg == ($clog2(CAL_CYCLES+1))'(CAL_CYCLES - 1);

  always_comb begin
    case (cal_state_reg)
      PLLCFG_CAL_IDLE: cal_state_next = cal_go ? PLLCFG_CAL_RUN : PLLCFG_CAL_IDLE;
      PLLCFG_CAL_RUN: cal_state_next = cal_last ? PLLCFG_CAL_DONE : PLLCFG_CAL_RUN;
      PLLCFG_CAL_DONE: cal_state_next = PLLCFG_CAL_IDLE;
      default: cal_state_next = PLLCFG_CAL_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state_reg <= PLLCFG_CAL_IDLE;
      cal_cnt_reg <= '0;
    end else begin
      cal_state_reg <= cal_state_next;
      cal_cnt_reg <= (cal_state_reg == PLLCFG_CAL_RUN) ? cal_cnt_reg + 1'b1 : '0;
    end
  end

  // divider edges come from another domain: two flops before any use
  logic [1:0] div_in, div_rise;
  assign div_in = {fb_div_in, ref_div_in};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_edge
      logic [1:0] sync_reg;
      logic prev_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_reg <= 2'b00;
          prev_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[0], div_in[g]};
          prev_reg <= sync_reg[1];
        end
      end
      assign div_rise[g] = sync_reg[1] & ~prev_reg;
    end
  endgenerate

  wire ref_rise = div_rise[0];
  wire fb_rise = div_rise[1];
  // both sides on: hold for the antibacklash width so no dead zone forms
  wire both = up_reg & dn_reg;
  wire abl_end = abl_cnt_reg == {1'b0, active_reg.abl};
  wire pfd_off = active_reg.pwr != `PLLCFG_PWR_ON;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      abl_cnt_reg <= 3'h0;
    end else if (pfd_off) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      abl_cnt_reg <= 3'h0;
    end else begin
      up_reg <= (both & abl_end) ? 1'b0 : (up_reg | ref_rise);
      dn_reg <= (both & abl_end) ? 1'b0 : (dn_reg | fb_rise);
      abl_cnt_reg <= (both & ~abl_end) ? abl_cnt_reg + 3'h1 : 3'h0;
    end
  end

  // negative polarity swaps the sense, but only for an external oscillator
  wire swap = active_reg.pol_neg & ~active_reg.src_vco;
  wire det_up = swap ? dn_reg : up_reg;
  wire det_dn = swap ? up_reg : dn_reg;

  always_comb begin
    pump_next = '{up: 1'b0, dn: 1'b0, hiz: 1'b1};
    if (!pfd_off) begin
      case (pllcfg_cp_mode_t'(active_reg.cp_mode))
        PLLCFG_CP_NORMAL: pump_next = '{up: det_up, dn: det_dn, hiz: 1'b0};
        PLLCFG_CP_UP: pump_next = '{up: 1'b1, dn: 1'b0, hiz: 1'b0};
        PLLCFG_CP_DN: pump_next = '{up: 1'b0, dn: 1'b1, hiz: 1'b0};
        PLLCFG_CP_HIZ: pump_next = '{up: 1'b0, dn: 1'b0, hiz: 1'b1};
        default: pump_next = '{up: 1'b0, dn: 1'b0, hiz: 1'b1};
      endcase
    end
  end

  // ratio shown as the divide value itself, 2 to 6
  wire [2:0] ratio_val = active_reg.ratio_code + `PLLCFG_RATIO_BASE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_reg <= '{up: 1'b0, dn: 1'b0, hiz: 1'b1};
    end else begin
      pump_reg <= pump_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_powered_down <= 1'b1;
      dist_from_vco <= 1'b0;
      vco_div_bypassed <= 1'b0;
      vco_div_ratio <= `PLLCFG_RST_RATIO + `PLLCFG_RATIO_BASE;
      antibacklash_sel <= 2'h0;
      pump_current_setting <= `PLLCFG_RST_CUR;
    end else begin
      pll_powered_down <= pfd_off;
      dist_from_vco <= active_reg.src_vco;
      vco_div_bypassed <= active_reg.div_bypass;
      vco_div_ratio <= ratio_val;
      antibacklash_sel <= active_reg.abl;
      pump_current_setting <= active_reg.pump_current_setting;
    end
  end

  // busy is registered from the next state, so it rises with the first run cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_cal_busy <= 1'b0;
    end else begin
      vco_cal_busy <= cal_state_next == PLLCFG_CAL_RUN;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pump_up = pump_reg.up;
  assign pump_dn = pump_reg.dn;
  assign pump_hiz = pump_reg.hiz;

endmodule : pllcfg_top
